// ---- rtl/clock_reset_generation.sv ----
// Function
// - Core clock enable times core, memory, ports
// - Ratio pins sampled while reset held
// - Peripheral clock is half core rate
// - Serial clock period equals peripheral times ratio
// - SPI clock period equals peripheral times baud
// - Ratios 6, 16, 32 plus software values
// - Core reset holds 4096 ref plus 2 core
// - Late release may add one ref cycle
//
// Implementation choices: the Wishbone slave port and the register addresses.
`default_nettype none
module clock_reset_generation
   import clkgen_pkg::*;
#(
   parameter int RST_REF = clkgen_pkg::RST_REF_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ref_clock_in_i,
   input wire logic reset_n_i,
   input wire logic [1:0] ratio_select_pins_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic core_clk_en_o,
   output logic periph_clk_en_o,
   output logic sport_clk_o,
   output logic spi_clk_o,
   output logic core_reset_o
);
   import clkgen_pkg::*;

   // The delay counter is 16 bits and the sequencer needs two reference edges at least
   if (RST_REF < 2 || RST_REF > 65535) begin : g_bad_rst_ref
      $error("RST_REF out of range");
   end

   // Board-side pins are asynchronous to clk_i
   logic ref_lvl, ref_rise, rstn_lvl;
   logic [1:0] pins_lvl;
   ref_sync #(.W(1)) u_ref (.clk_i(clk_i), .rst_i(rst_i), .d_i(ref_clock_in_i), .q_o(ref_lvl), .rise_o(ref_rise));
   ref_sync #(.W(1)) u_rst (.clk_i(clk_i), .rst_i(rst_i), .d_i(reset_n_i), .q_o(rstn_lvl), .rise_o());
   ref_sync #(.W(2)) u_pin (.clk_i(clk_i), .rst_i(rst_i), .d_i(ratio_select_pins_i), .q_o(pins_lvl), .rise_o());

   function automatic logic [5:0] pin_ratio(input logic [1:0] p);
      case (p)
         2'b00: pin_ratio = RATIO_00;
         2'b01: pin_ratio = RATIO_01;
         2'b10: pin_ratio = RATIO_10;
         default: pin_ratio = RATIO_11;
      endcase
   endfunction

   // Registers
   logic [5:0] pin_mult_r, pin_mult_nxt;
   logic [5:0] sw_mult_r, sw_mult_nxt;
   logic use_sw_r, use_sw_nxt;
   logic [15:0] sport_div_r, sport_div_nxt;
   logic [15:0] spi_div_r, spi_div_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [5:0] mult;
   logic wr_ok, acc;

   // Ack gates acc, so a request still held in its ack cycle is not taken twice
   assign acc = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_ok = acc && wb_we_i;
   assign mult = use_sw_r ? sw_mult_r : pin_mult_r;

   // Reset sequencer state
   rst_state_t st_r, st_nxt;
   logic [15:0] rcnt_r, rcnt_nxt;
   logic [1:0] ccnt_r, ccnt_nxt;
   logic core_rst_r, core_rst_nxt;

   always_comb begin
      pin_mult_nxt = pin_mult_r;
      sw_mult_nxt = sw_mult_r;
      use_sw_nxt = use_sw_r;
      sport_div_nxt = sport_div_r;
      spi_div_nxt = spi_div_r;
      ack_nxt = acc;
      dat_nxt = dat_r;
      if (!rstn_lvl) begin
         pin_mult_nxt = pin_ratio(pins_lvl);
         use_sw_nxt = 1'b0;
      end
      if (acc) begin
         dat_nxt = 32'h0000_0000;
         if (wb_adr_i == ADDR_CTRL) begin
            dat_nxt = {23'h0, use_sw_r, 2'b00, mult};
            if (wr_ok && wb_sel_i[0]) sw_mult_nxt = wb_dat_i[CTRL_MULT_LSB +: CTRL_MULT_W];
            if (wr_ok && wb_sel_i[1] && rstn_lvl) use_sw_nxt = wb_dat_i[CTRL_USE_SW];
         end else if (wb_adr_i == ADDR_SPORT) begin
            dat_nxt = {16'h0, sport_div_r};
            if (wr_ok && wb_sel_i[0]) sport_div_nxt[7:0] = wb_dat_i[7:0];
            if (wr_ok && wb_sel_i[1]) sport_div_nxt[15:8] = wb_dat_i[15:8];
         end else if (wb_adr_i == ADDR_SPI) begin
            dat_nxt = {16'h0, spi_div_r};
            if (wr_ok && wb_sel_i[0]) spi_div_nxt[7:0] = wb_dat_i[7:0];
            if (wr_ok && wb_sel_i[1]) spi_div_nxt[15:8] = wb_dat_i[15:8];
         end else if (wb_adr_i == ADDR_STATUS) begin
            dat_nxt = {28'h0, pins_lvl, rstn_lvl, core_rst_r};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_mult_r <= RATIO_00;
         sw_mult_r <= RATIO_00;
         use_sw_r <= 1'b0;
         sport_div_r <= SPORT_DIV_RST;
         spi_div_r <= SPI_DIV_RST;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         pin_mult_r <= pin_mult_nxt;
         sw_mult_r <= sw_mult_nxt;
         use_sw_r <= use_sw_nxt;
         sport_div_r <= sport_div_nxt;
         spi_div_r <= spi_div_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Core clock: mult back-to-back enables in one burst after each reference edge. Without a PLL
   // the core rate is emulated as ticks of clk_i; the first tick lands two clocks after ref_rise.
   logic [5:0] cpend_r, cpend_nxt;
   logic cen_r, cen_nxt;
   logic pen_r, pen_nxt;
   logic ph_r, ph_nxt;
   always_comb begin
      cpend_nxt = cpend_r;
      cen_nxt = 1'b0;
      if (ref_rise) begin
         cpend_nxt = mult;
      end else if (cpend_r != 6'h00) begin
         cpend_nxt = cpend_r - 6'h01;
         cen_nxt = 1'b1;
      end
      ph_nxt = cen_nxt ? ~ph_r : ph_r;
      pen_nxt = cen_nxt && ph_r;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpend_r <= 6'h00;
         cen_r <= 1'b0;
         pen_r <= 1'b0;
         ph_r <= 1'b0;
      end else begin
         cpend_r <= cpend_nxt;
         cen_r <= cen_nxt;
         pen_r <= pen_nxt;
         ph_r <= ph_nxt;
      end
   end
   assign core_clk_en_o = cen_r;
   assign periph_clk_en_o = pen_r;

   div_if sport_bus ();
   div_if spi_bus ();
   assign sport_bus.ratio = sport_div_r;
   assign spi_bus.ratio = spi_div_r;
   ratio_divider u_sport (.clk_i(clk_i), .rst_i(rst_i), .en_i(pen_r), .d(sport_bus.div));
   ratio_divider u_spi (.clk_i(clk_i), .rst_i(rst_i), .en_i(pen_r), .d(spi_bus.div));
   assign sport_clk_o = sport_bus.clk_out;
   assign spi_clk_o = spi_bus.clk_out;

   // Reset sequencer
   always_comb begin
      st_nxt = st_r;
      rcnt_nxt = rcnt_r;
      ccnt_nxt = ccnt_r;
      core_rst_nxt = 1'b1;
      case (st_r)
         RS_HOLD: begin
            rcnt_nxt = 16'h0000;
            if (rstn_lvl) st_nxt = RS_COUNT;
         end
         RS_COUNT: begin
            if (ref_rise) rcnt_nxt = rcnt_r + 16'h0001;
            if (ref_rise && rcnt_r == 16'(RST_REF - 1)) begin
               st_nxt = RS_TAIL;
               ccnt_nxt = 2'b00;
            end
         end
         RS_TAIL: begin
            if (cen_nxt) ccnt_nxt = ccnt_r + 2'b01;
            if (cen_nxt && ccnt_r == 2'(RST_CORE_CYCLES - 1)) begin
               st_nxt = RS_RUN;
               core_rst_nxt = 1'b0;
            end
         end
         default: core_rst_nxt = 1'b0;
      endcase
      if (!rstn_lvl) begin
         st_nxt = RS_HOLD;
         core_rst_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= RS_HOLD;
         rcnt_r <= 16'h0000;
         ccnt_r <= 2'b00;
         core_rst_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         rcnt_r <= rcnt_nxt;
         ccnt_r <= ccnt_nxt;
         core_rst_r <= core_rst_nxt;
      end
   end
   assign core_reset_o = core_rst_r;

   // Checks
   a_core_held: assert property (@(posedge clk_i) disable iff (rst_i)
      !rstn_lvl |=> core_reset_o) else $error("core reset released while pin low");
   a_count_ref: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r == RS_COUNT && !ref_rise && rstn_lvl) |=> $stable(rcnt_r)) else $error("count moved without ref edge");
   a_release_cnt: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> $past(rcnt_r) == 16'(RST_REF)) else $error("release before full ref count");
   a_tail_core: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> $past(st_r) == RS_TAIL && $past(cen_nxt)) else $error("release not on core tick");
   a_pin_sample: assert property (@(posedge clk_i) disable iff (rst_i)
      !rstn_lvl |=> pin_mult_r == pin_ratio($past(pins_lvl))) else $error("ratio pins not sampled");
   a_periph_half: assert property (@(posedge clk_i) disable iff (rst_i)
      periph_clk_en_o |-> core_clk_en_o) else $error("peripheral tick off core tick");
   a_core_burst: assert property (@(posedge clk_i) disable iff (rst_i)
      (ref_rise && mult != 6'h00) |=> ##1 core_clk_en_o) else $error("no core tick after ref edge");
   a_ratio_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ok && wb_adr_i == ADDR_CTRL && wb_sel_i[1:0] == 2'b11 && wb_dat_i[CTRL_USE_SW] && rstn_lvl)
      |=> mult == $past(wb_dat_i[CTRL_MULT_LSB +: CTRL_MULT_W])) else $error("software ratio not applied");

   // Core ticks since the last peripheral tick; only the ratio check reads it
   logic [1:0] since_pen_r, since_pen_nxt;
   always_comb begin
      since_pen_nxt = since_pen_r;
      if (periph_clk_en_o) begin
         since_pen_nxt = 2'b00;
      end else if (core_clk_en_o && since_pen_r != 2'b11) begin
         since_pen_nxt = since_pen_r + 2'b01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_pen_r <= 2'b00;
      end else begin
         since_pen_r <= since_pen_nxt;
      end
   end
   a_periph_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
      core_clk_en_o |-> (periph_clk_en_o == (since_pen_r == 2'b01))) else $error("periph ratio off");

   // Core ticks counted per reference period against the ratio loaded at its edge.
   // A reference faster than mult+2 clocks truncates the burst, and this check says so.
   logic [6:0] burst_r, burst_nxt;
   logic [5:0] burst_mult_r, burst_mult_nxt;
   logic burst_ok_r, burst_ok_nxt;
   always_comb begin
      burst_nxt = burst_r;
      burst_mult_nxt = burst_mult_r;
      burst_ok_nxt = burst_ok_r;
      if (ref_rise) begin
         burst_nxt = 7'h00;
         burst_mult_nxt = mult;
         burst_ok_nxt = 1'b1;
      end else if (core_clk_en_o && burst_r != 7'h7f) begin
         burst_nxt = burst_r + 7'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         burst_r <= 7'h00;
         burst_mult_r <= 6'h00;
         burst_ok_r <= 1'b0;
      end else begin
         burst_r <= burst_nxt;
         burst_mult_r <= burst_mult_nxt;
         burst_ok_r <= burst_ok_nxt;
      end
   end
   a_burst_len: assert property (@(posedge clk_i) disable iff (rst_i)
      (ref_rise && burst_ok_r) |-> burst_r == {1'b0, burst_mult_r}) else $error("core tick count off ratio");

   c_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(core_reset_o));
   c_sw_ratio: cover property (@(posedge clk_i) disable iff (rst_i) use_sw_r && core_clk_en_o);
   c_rereset: cover property (@(posedge clk_i) disable iff (rst_i) st_r == RS_COUNT ##1 st_r == RS_HOLD);
   c_ratio_32: cover property (@(posedge clk_i) disable iff (rst_i) !rstn_lvl && pin_mult_r == RATIO_01);
   c_sport_tick: cover property (@(posedge clk_i) disable iff (rst_i) sport_bus.tick && sport_div_r == 16'h0003);
endmodule
`default_nettype wire

// ---- rtl/clkgen_pkg.sv ----
`default_nettype none
package clkgen_pkg;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SPORT = 8'h04;
   localparam logic [7:0] ADDR_SPI = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int CTRL_MULT_LSB = 0;
   localparam int CTRL_MULT_W = 6;
   localparam int CTRL_USE_SW = 8;
   localparam logic [5:0] RATIO_00 = 6'h06;
   localparam logic [5:0] RATIO_01 = 6'h20;
   localparam logic [5:0] RATIO_10 = 6'h10;
   localparam logic [5:0] RATIO_11 = 6'h06;
   localparam logic [15:0] SPORT_DIV_RST = 16'h0002;
   localparam logic [15:0] SPI_DIV_RST = 16'h0004;
   localparam int RST_REF_CYCLES = 4096;
   localparam int RST_CORE_CYCLES = 2;
   typedef enum logic [1:0] {
      RS_HOLD = 2'b00,
      RS_COUNT = 2'b01,
      RS_TAIL = 2'b10,
      RS_RUN = 2'b11
   } rst_state_t;
endpackage
`default_nettype wire

// ---- rtl/div_if.sv ----
`default_nettype none
interface div_if;
   logic [15:0] ratio;
   logic tick;
   logic clk_out;
   modport ctl(output ratio, input tick, input clk_out);
   modport div(input ratio, output tick, output clk_out);
endinterface
`default_nettype wire

// ---- rtl/ratio_divider.sv ----
`default_nettype none
// Divides a base enable into a clock level; period is ratio base ticks, and 2 base ticks for a ratio below 2
module ratio_divider (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   div_if.div d
);
   logic [15:0] cnt_r, cnt_nxt;
   logic lvl_r, lvl_nxt;
   logic tick_nxt;
   logic tick_r;
   logic [15:0] r;
   always_comb begin
      r = (d.ratio < 16'h0002) ? 16'h0002 : d.ratio;
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      tick_nxt = 1'b0;
      if (en_i) begin
         if (cnt_r >= r - 16'h0001) begin
            cnt_nxt = 16'h0000;
            lvl_nxt = 1'b1;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 == (r >> 1)) begin
               lvl_nxt = 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 16'h0000;
         lvl_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
         tick_r <= tick_nxt;
      end
   end
   assign d.tick = tick_r;
   assign d.clk_out = lvl_r;
endmodule
`default_nettype wire

// ---- rtl/ref_sync.sv ----
`default_nettype none
// Two-flop synchroniser plus rising-edge detect on the synchronised level
module ref_sync #(parameter int W = 1) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o,
   output logic [W-1:0] rise_o
);
   logic [W-1:0] s1_r, s2_r, s3_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign q_o = s2_r;
   assign rise_o = s2_r & ~s3_r;
endmodule
`default_nettype wire

// ---- dv/board_model.sv ----
`default_nettype none
// Board side: free-running reference, reset pin and ratio pins
module board_model #(
   parameter int HALF = 40,
   parameter int LOW_REF = 32
) (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [1:0] pins_i,
   output logic ref_clock_in_o,
   output logic reset_n_o,
   output logic [1:0] ratio_select_pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph = 0;
   int low = 0;
   initial begin
      ref_clock_in_o = 1'b0;
      reset_n_o = 1'b0;
      ratio_select_pins_o = 2'b00;
   end
   // Oscillator source, running from time zero: no crystal start-up to wait
   // Slower than the pin limit: the emulated core needs mult+2 clocks per period
   always @(posedge clk_i) begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) begin
         ref_clock_in_o <= ~ref_clock_in_o;
      end
      if (start_i) begin
         reset_n_o <= 1'b0;
         ratio_select_pins_o <= pins_i;
         low <= 0;
      end else if (ph == HALF - 1 && !ref_clock_in_o) begin
         if (!reset_n_o) begin
            // Pins held and reference running for 32 periods, about 20 us
            if (low >= LOW_REF) begin
               reset_n_o <= 1'b1;
            end else begin
               low <= low + 1;
            end
         end else begin
            // Pins are not held once reset is over
            ratio_select_pins_o <= ~ratio_select_pins_o;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import clkgen_pkg::*;
   localparam int RST = 8;
   localparam int PER = 80;
   localparam int LIMIT = 50000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic start = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [1:0] pins = 2'b00;
   logic [5:0] tbl [4] = '{RATIO_00, RATIO_01, RATIO_10, RATIO_11};
   wire ref_clk, rst_n, ack, core_en, per_en, sport_clk, spi_clk, core_rst;
   wire [1:0] cfg;
   wire [31:0] dat_o;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   int m;
   always #4 clk_i = ~clk_i;
   clock_reset_generation #(.RST_REF(RST)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ref_clock_in_i(ref_clk),
      .reset_n_i(rst_n), .ratio_select_pins_i(cfg), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .core_clk_en_o(core_en), .periph_clk_en_o(per_en), .sport_clk_o(sport_clk), .spi_clk_o(spi_clk),
      .core_reset_o(core_rst));
   board_model #(.HALF(PER / 2)) board (.clk_i(clk_i), .start_i(start), .pins_i(pins),
      .ref_clock_in_o(ref_clk), .reset_n_o(rst_n), .ratio_select_pins_o(cfg));
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         give_verdict();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic near(input int a, input int b);
      return (a - b <= 1) && (b - a <= 1);
   endfunction
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task kick(input logic [1:0] p);
      @(posedge clk_i);
      start <= 1'b1;
      pins <= p;
      @(posedge clk_i);
      start <= 1'b0;
      while (rst_n !== 1'b0) @(negedge clk_i);
   endtask
   // Reference edges from reset pin release until core reset falls
   task rel(output int c);
      logic prev;
      c = 0;
      while (rst_n !== 1'b1) @(negedge clk_i);
      prev = ref_clk;
      while (core_rst !== 1'b0) begin
         @(negedge clk_i);
         if (ref_clk === 1'b1 && prev === 1'b0) c++;
         prev = ref_clk;
      end
   endtask
   // Window starts where the design sees the reference edge, three clocks late
   task win(output int c, output int q);
      c = 0;
      q = 0;
      @(posedge ref_clk);
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 8 * PER; i++) begin
         @(negedge clk_i);
         c += (core_en === 1'b1);
         q += (per_en === 1'b1);
      end
   endtask
   task div(input logic s, output int c);
      logic prev;
      logic cur;
      int k;
      c = 0;
      k = 0;
      prev = s ? spi_clk : sport_clk;
      while (k < 2) begin
         @(negedge clk_i);
         cur = s ? spi_clk : sport_clk;
         if (k == 1 && per_en === 1'b1) c++;
         if (cur === 1'b1 && prev === 1'b0) k++;
         prev = cur;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rel(n);
      check(n inside {RST, RST + 1}, 1'b1);
      wb(1'b0, ADDR_SPORT, 32'h0);
      check(rdat[15:0], SPORT_DIV_RST);
      wb(1'b0, ADDR_SPI, 32'h0);
      check(rdat[15:0], SPI_DIV_RST);
      for (int p = 0; p < 4; p++) begin
         kick(p[1:0]);
         while (rst_n !== 1'b1) @(negedge clk_i);
         repeat (3) @(posedge ref_clk);
         @(negedge clk_i);
         check(core_rst, 1'b1);
         kick(p[1:0]);
         repeat (4) @(posedge clk_i);
         wb(1'b0, ADDR_STATUS, 32'h0);
         check(rdat[3:0], {p[1:0], 2'b01});
         rel(n);
         check(n inside {RST, RST + 1}, 1'b1);
         wb(1'b0, ADDR_CTRL, 32'h0);
         check(rdat[5:0], tbl[p]);
         win(n, m);
         check(near(n, 8 * tbl[p]), 1'b1);
         check(near(m, 4 * tbl[p]), 1'b1);
      end
      wb(1'b1, ADDR_SPORT, 32'h3);
      wb(1'b1, ADDR_SPI, 32'h5);
      wb(1'b1, 8'h40, 32'h7);
      wb(1'b0, 8'h40, 32'h0);
      check(rdat, 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h10a);
      wb(1'b0, ADDR_CTRL, 32'h0);
      check(rdat[5:0], 6'h0a);
      check(rdat[8], 1'b1);
      @(posedge ref_clk);
      win(n, m);
      check(near(n, 80), 1'b1);
      check(near(m, 40), 1'b1);
      div(1'b0, n);
      div(1'b0, n);
      check(n, 32'h3);
      div(1'b1, n);
      div(1'b1, n);
      check(n, 32'h5);
      give_verdict();
   end
endmodule
`default_nettype wire
